// ### common/relay_pkg.sv
// Constants, register map and carrier types for the input filter and marker block.
package relay_pkg;

   // Clock and filter timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_MS_NS    = 1_000_000;
   localparam int MS_CYCLES     = (TICK_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] SLOW_ON_MS   = 7'd25;
   localparam logic [6:0] SLOW_OFF_MS  = 7'd20;
   localparam logic [6:0] STD_ON_MS    = 7'd5;
   localparam logic [6:0] STD_OFF_MS   = 7'd5;
   localparam logic [6:0] SLAVE_ON_MS  = 7'd5;
   localparam logic [6:0] SLAVE_HOLD_MS = 7'd100;
   localparam int SLOW_FILT_INPUTS = 8;

   // Marker layout.
   localparam int NUM_MARKERS  = 64;
   localparam int NUM_AOUT     = 8;
   localparam int NUM_AIN      = 8;
   localparam int MAX_DO       = 20;
   localparam int BLANK_SINKS  = 64;
   localparam int STARTUP_BIT  = 7;
   localparam int RUN_BASE_BIT = 24;
   localparam int RUN_DISP_BIT = 25;
   localparam int CHARSET_BIT  = 26;
   localparam int SET_BASE_BIT = 27;
   localparam int FLT_BASE_BIT = 28;
   localparam int SET_DISP_BIT = 29;
   localparam int FLT_DISP_BIT = 30;

   // Program resource limits.
   localparam logic [13:0] LIMIT_BYTES  = 14'd8500;
   localparam logic [8:0]  LIMIT_BLOCKS = 9'd400;
   localparam logic [7:0]  LIMIT_REM    = 8'd250;

   // Register byte offsets.
   localparam logic [11:0] CTRL_OFS     = 12'h000;
   localparam logic [11:0] STATUS_OFS   = 12'h004;
   localparam logic [11:0] DI_OFS       = 12'h008;
   localparam logic [11:0] MARK_LO_OFS  = 12'h00C;
   localparam logic [11:0] MARK_HI_OFS  = 12'h010;
   localparam logic [11:0] RES_COST_OFS = 12'h014;
   localparam logic [11:0] RES_CMD_OFS  = 12'h018;
   localparam logic [11:0] RES_USED_OFS = 12'h01C;
   localparam logic [11:0] HSC_OFS      = 12'h020;
   localparam logic [11:0] AOUT_SEL_OFS = 12'h024;
   localparam logic [11:0] AMARK_OFS    = 12'h100;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Product variant and operating mode.
   typedef enum logic [1:0] {VAR_STD, VAR_SLOW, VAR_FAST} variant_e;
   typedef enum logic [1:0] {MODE_STOP, MODE_RUN, MODE_PROG, MODE_PARAM} mode_e;

   // Control register fields.
   typedef struct packed {
      logic [22:0] spare;
      logic        charset_default;
      logic        charset_in_prog;
      logic        diag_error;
      mode_e       mode;
      logic        ai_four;
      logic        slave;
      variant_e    variant;
   } ctrl_s;

   // Cost of one program element.
   typedef struct packed {
      logic [7:0]  rem;
      logic [7:0]  spare;
      logic [15:0] bytes;
   } cost_s;

   // Analog output source selection: class 0 analog input, 1 marker, 2 analog output.
   typedef struct packed {
      logic [2:0] target;
      logic [1:0] src_class;
      logic [5:0] src_index;
   } aout_sel_s;

endpackage : relay_pkg

// ### rtl/input_filter_markers.sv
// Input debounce, I/O numbering, marker cells, system markers and resource accounting.
`timescale 1ns/10ps
module input_filter_markers
   import relay_pkg::*;
#(
   parameter int BASE_DI   = 8,
   parameter int EXP_DI    = 16,
   parameter int BASE_DO   = 4,
   parameter int NUM_DO    = 20,
   parameter int MS_CYC    = MS_CYCLES
)(
   // Clock, reset and clock enable.
   input  wire logic                       mclk_in,
   input  wire logic                       rst_in,
   input  wire logic                       ce_in,
   // AXI4-Lite register slave.
   input  wire logic [11:0]                s_awaddr_in,
   input  wire logic                       s_awvalid_in,
   output logic                            s_awready_out,
   input  wire logic [31:0]                s_wdata_in,
   input  wire logic [3:0]                 s_wstrb_in,
   input  wire logic                       s_wvalid_in,
   output logic                            s_wready_out,
   output logic [1:0]                      s_bresp_out,
   output logic                            s_bvalid_out,
   input  wire logic                       s_bready_in,
   input  wire logic [11:0]                s_araddr_in,
   input  wire logic                       s_arvalid_in,
   output logic                            s_arready_out,
   output logic [31:0]                     s_rdata_out,
   output logic [1:0]                      s_rresp_out,
   output logic                            s_rvalid_out,
   input  wire logic                       s_rready_in,
   // Input pins and circuit program view.
   input  wire logic [BASE_DI+EXP_DI-1:0]  din_pin_in,
   output logic [BASE_DI+EXP_DI-1:0]       prog_di_out,
   output logic [3:0]                      analog_ch_en_out,
   input  wire logic [NUM_AIN-1:0][15:0]   analog_in_in,
   // Outputs, markers and message sinks.
   input  wire logic [NUM_DO-1:0]          prog_do_in,
   output logic [BASE_DO-1:0]              base_do_out,
   output logic [NUM_DO-BASE_DO-1:0]       exp_do_out,
   input  wire logic [NUM_MARKERS-1:0]     prog_marker_in,
   output logic [NUM_MARKERS-1:0]          marker_out,
   input  wire logic [BLANK_SINKS-1:0]     blank_sink_in,
   input  wire logic [BLANK_SINKS-1:0]     msg_charset2_in,
   output logic [BLANK_SINKS-1:0]          msg_show_out,
   output logic [NUM_AOUT-1:0][15:0]       analog_out_out,
   // Backlight drives.
   output logic                            run_light_base_out,
   output logic                            run_light_display_out,
   output logic                            setup_light_base_out,
   output logic                            setup_light_display_out,
   output logic                            fault_light_base_out,
   output logic                            fault_light_display_out
);
   localparam int NDI = BASE_DI + EXP_DI;

   // Elaboration-time checks.
   if (NUM_DO > MAX_DO || BASE_DO >= NUM_DO || BASE_DI < 8 || NDI > 32 || MS_CYC < 1)
      $error("input_filter_markers: unsupported parameter values");

   typedef struct packed {
      logic [NDI-1:0][2:0]        sync;
      logic [NDI-1:0]             seen;
      logic [NDI-1:0]             level;
      logic [NDI-1:0][6:0]        cnt;
      logic [31:0]                ms_cnt;
      logic [3:0][7:0]            hsc;
      ctrl_s                      ctrl;
      logic                       first_scan;
      logic                       was_run;
      logic [NUM_MARKERS-1:0]     mark_cur;
      logic [NUM_MARKERS-1:0]     net_val;
      logic [NUM_MARKERS-1:0]     net_pend;
      logic [NUM_MARKERS-1:0][15:0] am_next;
      logic [NUM_MARKERS-1:0][15:0] am_cur;
      logic [NUM_AOUT-1:0][1:0]   ao_cls;
      logic [NUM_AOUT-1:0][5:0]   ao_idx;
      logic [NUM_AOUT-1:0][15:0]  ao_val;
      cost_s                      cost;
      logic [13:0]                used_b;
      logic [8:0]                 used_k;
      logic [7:0]                 used_r;
      logic                       aw_got;
      logic                       w_got;
      logic [11:0]                awaddr;
      logic [31:0]                wdata;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       rvalid;
      logic [31:0]                rdata;
      logic [1:0]                 rresp;
   } state_s;

   state_s s_q;
   state_s s_d;

   // On or off delay for one input, chosen by variant, slave mode and position.
   function automatic logic [6:0] filt_delay(input ctrl_s c, input int idx, input logic rise);
      logic [6:0] d;
      d = rise ? STD_ON_MS : STD_OFF_MS;
      if (c.slave)
         d = rise ? SLAVE_ON_MS : SLAVE_HOLD_MS;
      else if (c.variant == VAR_SLOW && idx < SLOW_FILT_INPUTS)
         d = rise ? SLOW_ON_MS : SLOW_OFF_MS;
      return d;
   endfunction : filt_delay

   // Whether an analog source is legal for an analog sink, and its range.
   function automatic logic aout_src_ok(input logic [1:0] cls, input logic [5:0] idx);
      logic ok;
      ok = 1'b0;
      case (cls)
         2'd0:    ok = (idx < 6'(NUM_AIN));
         2'd1:    ok = 1'b1;
         2'd2:    ok = (idx < 6'(NUM_AOUT));
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : aout_src_ok

   // Resource check of the staged element against the remaining space.
   logic fits;
   always_comb
   begin
      fits = (s_q.used_k < LIMIT_BLOCKS)
         && ({3'b000, s_q.used_b} + {1'b0, s_q.cost.bytes} <= {3'b000, LIMIT_BYTES})
         && ({1'b0, s_q.used_r} + {1'b0, s_q.cost.rem} <= {1'b0, LIMIT_REM});
   end

   logic ms_tick;
   logic charset_act;
   assign ms_tick = (s_q.ms_cnt == 32'(MS_CYC - 1));
   assign charset_act = s_q.ctrl.charset_in_prog ? s_q.mark_cur[CHARSET_BIT]
                                                 : s_q.ctrl.charset_default;

   // Next-state logic for filters, markers, resources and the register bus.
   always_comb
   begin
      logic [11:0] ra;
      logic        wr_fire;
      logic        ok;
      logic [NUM_MARKERS-1:0] nxt;
      aout_sel_s   sel;
      s_d = s_q;
      ra = s_araddr_in;
      wr_fire = 1'b0;
      ok = 1'b0;
      nxt = '0;
      sel = aout_sel_s'(s_q.wdata[10:0]);
      s_d.ms_cnt = ms_tick ? 32'd0 : s_q.ms_cnt + 32'd1;
      for (int i = 0; i < NDI; i++)
      begin
         s_d.sync[i] = {s_q.sync[i][1:0], din_pin_in[i]};
         if (s_q.sync[i][1] == s_q.sync[i][2])
            s_d.seen[i] = s_q.sync[i][2];
         if (ms_tick)
         begin
            if (s_q.seen[i] != s_q.level[i])
            begin
               if (s_q.cnt[i] + 7'd1 >= filt_delay(s_q.ctrl, i, s_q.seen[i]))
               begin
                  s_d.level[i] = s_q.seen[i];
                  s_d.cnt[i] = 7'd0;
               end
               else
                  s_d.cnt[i] = s_q.cnt[i] + 7'd1;
            end
            else
               s_d.cnt[i] = 7'd0;
         end
      end
      // Fast counters count agreed rising edges on inputs three to six.
      for (int k = 0; k < 4; k++)
         if (s_q.ctrl.variant == VAR_FAST && s_d.seen[k + 2] && !s_q.seen[k + 2])
            s_d.hsc[k] = s_q.hsc[k] + 8'd1;
      // Scan boundary: markers capture what was presented during the scan.
      if (ms_tick)
      begin
         nxt = prog_marker_in;
         for (int m = 0; m < NUM_MARKERS; m++)
            if (s_q.net_pend[m])
               nxt[m] = s_q.net_val[m];
         if (!s_q.ctrl.charset_in_prog)
            nxt[CHARSET_BIT] = 1'b0;
         nxt[RUN_BASE_BIT] = nxt[RUN_BASE_BIT] | (s_q.ctrl.mode == MODE_RUN);
         nxt[RUN_DISP_BIT] = nxt[RUN_DISP_BIT] | (s_q.ctrl.mode == MODE_RUN);
         nxt[SET_BASE_BIT] = nxt[SET_BASE_BIT] | s_q.ctrl.mode[1];
         nxt[SET_DISP_BIT] = nxt[SET_DISP_BIT] | s_q.ctrl.mode[1];
         nxt[FLT_BASE_BIT] = nxt[FLT_BASE_BIT] | s_q.ctrl.diag_error;
         nxt[FLT_DISP_BIT] = nxt[FLT_DISP_BIT] | s_q.ctrl.diag_error;
         s_d.first_scan = (s_q.ctrl.mode == MODE_RUN) && !s_q.was_run;
         if (s_d.first_scan)
            nxt[STARTUP_BIT] = 1'b1;
         s_d.was_run = (s_q.ctrl.mode == MODE_RUN);
         s_d.mark_cur = nxt;
         s_d.net_pend = '0;
         s_d.am_cur = s_q.am_next;
         for (int a = 0; a < NUM_AOUT; a++)
            case (s_q.ao_cls[a])
               2'd0:    s_d.ao_val[a] = analog_in_in[s_q.ao_idx[a][2:0]];
               2'd1:    s_d.ao_val[a] = s_q.am_cur[s_q.ao_idx[a]];
               2'd2:    s_d.ao_val[a] = s_q.ao_val[s_q.ao_idx[a][2:0]];
               default: s_d.ao_val[a] = s_q.ao_val[a];
            endcase
      end
      // Write address and data are taken independently.
      if (s_awvalid_in && !s_q.aw_got && !s_q.bvalid)
      begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_awaddr_in;
      end
      if (s_wvalid_in && !s_q.w_got && !s_q.bvalid)
      begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_wdata_in;
      end
      wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
      if (wr_fire)
      begin
         ok = 1'b1;
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         case (s_q.awaddr[11:2])
            CTRL_OFS[11:2]:     s_d.ctrl = ctrl_s'(s_q.wdata);
            MARK_LO_OFS[11:2]:
            begin
               s_d.net_val[31:0] = s_q.wdata;
               s_d.net_pend[31:0] = '1;
            end
            MARK_HI_OFS[11:2]:
            begin
               s_d.net_val[63:32] = s_q.wdata;
               s_d.net_pend[63:32] = '1;
            end
            RES_COST_OFS[11:2]: s_d.cost = cost_s'(s_q.wdata);
            RES_CMD_OFS[11:2]:
            begin
               if (s_q.wdata[1])
               begin
                  s_d.used_b = '0;
                  s_d.used_k = '0;
                  s_d.used_r = '0;
               end
               else if (s_q.wdata[0] && fits)
               begin
                  s_d.used_b = s_q.used_b + s_q.cost.bytes[13:0];
                  s_d.used_k = s_q.used_k + 9'd1;
                  s_d.used_r = s_q.used_r + s_q.cost.rem;
               end
               else if (s_q.wdata[0])
                  ok = 1'b0;
            end
            AOUT_SEL_OFS[11:2]:
            begin
               ok = aout_src_ok(sel.src_class, sel.src_index);
               if (ok)
               begin
                  s_d.ao_cls[sel.target] = sel.src_class;
                  s_d.ao_idx[sel.target] = sel.src_index;
               end
            end
            default:
            begin
               ok = (s_q.awaddr[11:8] == AMARK_OFS[11:8]);
               if (ok)
                  s_d.am_next[s_q.awaddr[7:2]] = s_q.wdata[15:0];
            end
         endcase
         s_d.bvalid = 1'b1;
         s_d.bresp = ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.bvalid && s_bready_in)
         s_d.bvalid = 1'b0;
      // Reads answer one cycle after the address is taken.
      if (s_q.rvalid && s_rready_in)
         s_d.rvalid = 1'b0;
      if (s_arvalid_in && !s_q.rvalid)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         case (ra[11:2])
            CTRL_OFS[11:2]:     s_d.rdata = 32'(s_q.ctrl);
            STATUS_OFS[11:2]:   s_d.rdata = {29'h0, charset_act, fits, s_q.first_scan};
            DI_OFS[11:2]:       s_d.rdata = 32'(s_q.level);
            MARK_LO_OFS[11:2]:  s_d.rdata = s_q.mark_cur[31:0];
            MARK_HI_OFS[11:2]:  s_d.rdata = s_q.mark_cur[63:32];
            RES_COST_OFS[11:2]: s_d.rdata = 32'(s_q.cost);
            RES_CMD_OFS[11:2]:  s_d.rdata = 32'h0000_0000;
            RES_USED_OFS[11:2]: s_d.rdata = {s_q.used_r, s_q.used_k[7:0],
                                             1'b0, s_q.used_k[8], s_q.used_b};
            HSC_OFS[11:2]:      s_d.rdata = s_q.hsc;
            AOUT_SEL_OFS[11:2]: s_d.rdata = 32'h0000_0000;
            default:
            begin
               if (ra[11:8] == AMARK_OFS[11:8])
                  s_d.rdata = {16'h0000, s_q.am_cur[ra[7:2]]};
               else
                  s_d.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q <= '0;
      end
      else if (ce_in)
      begin
         s_q <= s_d;
      end
   end

   // Bus handshakes.
   assign s_awready_out = !s_q.aw_got && !s_q.bvalid;
   assign s_wready_out  = !s_q.w_got && !s_q.bvalid;
   assign s_bvalid_out  = s_q.bvalid;
   assign s_bresp_out   = s_q.bresp;
   assign s_arready_out = !s_q.rvalid;
   assign s_rvalid_out  = s_q.rvalid;
   assign s_rdata_out   = s_q.rdata;
   assign s_rresp_out   = s_q.rresp;

   // Inputs in base-then-expansion order, and analog channel mapping.
   assign prog_di_out = s_q.level;
   assign analog_ch_en_out[0] = (s_q.ctrl.variant == VAR_FAST);
   assign analog_ch_en_out[1] = (s_q.ctrl.variant == VAR_FAST);
   assign analog_ch_en_out[2] = (s_q.ctrl.variant == VAR_FAST) && s_q.ctrl.ai_four;
   assign analog_ch_en_out[3] = (s_q.ctrl.variant == VAR_FAST) && s_q.ctrl.ai_four;

   // Outputs numbered base first, expansion after; blank sinks only trigger messages.
   assign base_do_out  = prog_do_in[BASE_DO-1:0];
   assign exp_do_out   = prog_do_in[NUM_DO-1:BASE_DO];
   assign msg_show_out = blank_sink_in & (charset_act ? msg_charset2_in
                                                      : ~msg_charset2_in);
   assign marker_out   = s_q.mark_cur;
   assign analog_out_out = s_q.ao_val;

   // Backlights follow their marker cells.
   assign run_light_base_out      = s_q.mark_cur[RUN_BASE_BIT];
   assign run_light_display_out   = s_q.mark_cur[RUN_DISP_BIT];
   assign setup_light_base_out    = s_q.mark_cur[SET_BASE_BIT];
   assign setup_light_display_out = s_q.mark_cur[SET_DISP_BIT];
   assign fault_light_base_out    = s_q.mark_cur[FLT_BASE_BIT];
   assign fault_light_display_out = s_q.mark_cur[FLT_DISP_BIT];

endmodule : input_filter_markers

// ### verification/input_filter_markers_sva.sv
// Concurrent checks on the ports of the input filter and marker block.
`timescale 1ns/10ps
module input_filter_markers_sva
   import relay_pkg::*;
#(
   parameter int BASE_DO = 4,
   parameter int NUM_DO  = 20
)(
   // Clock, reset and enable.
   input wire logic                      mclk_in,
   input wire logic                      rst_in,
   input wire logic                      ce_in,
   // Register bus.
   input wire logic                      s_awvalid_in,
   input wire logic                      s_awready_out,
   input wire logic                      s_wvalid_in,
   input wire logic                      s_wready_out,
   input wire logic [1:0]                s_bresp_out,
   input wire logic                      s_bvalid_out,
   input wire logic                      s_bready_in,
   input wire logic                      s_arvalid_in,
   input wire logic                      s_arready_out,
   input wire logic [31:0]               s_rdata_out,
   input wire logic                      s_rvalid_out,
   input wire logic                      s_rready_in,
   // Program view.
   input wire logic [NUM_DO-1:0]         prog_do_in,
   input wire logic [BASE_DO-1:0]        base_do_out,
   input wire logic [NUM_DO-BASE_DO-1:0] exp_do_out,
   input wire logic [NUM_MARKERS-1:0]    marker_out
);
   // All checks share the one clock and its reset.
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   AST_DO_MAP: assert property ({exp_do_out, base_do_out} == prog_do_in)
      else $error("output numbering wrong");
   AST_MARK_HOLD: assert property ($changed(marker_out) |=> $stable(marker_out)[*8])
      else $error("marker moved inside a scan");
   AST_STARTUP: assert property ($rose(marker_out[STARTUP_BIT]) |->
      marker_out[STARTUP_BIT][*8] ##[1:3] !marker_out[STARTUP_BIT])
      else $error("startup marker not one scan");
   AST_B_LAT: assert property (ce_in && s_awvalid_in && s_awready_out && s_wvalid_in
      && s_wready_out |-> ##[1:3] s_bvalid_out) else $error("write answer late");
   AST_R_LAT: assert property (ce_in && s_arvalid_in && s_arready_out
      |-> ##[1:2] s_rvalid_out) else $error("read answer late");
   AST_B_HOLD: assert property (s_bvalid_out && !s_bready_in
      |=> s_bvalid_out && $stable(s_bresp_out)) else $error("write answer dropped");
   AST_R_HOLD: assert property (s_rvalid_out && !s_rready_in
      |=> s_rvalid_out && $stable(s_rdata_out)) else $error("read answer dropped");
   AST_AW_STALL: assert property (s_bvalid_out |-> !s_awready_out && !s_wready_out)
      else $error("write taken while answer pending");
endmodule : input_filter_markers_sva

bind input_filter_markers input_filter_markers_sva #(.BASE_DO(BASE_DO), .NUM_DO(NUM_DO)) u_sva (
   .mclk_in, .rst_in, .ce_in, .s_awvalid_in, .s_awready_out, .s_wvalid_in, .s_wready_out,
   .s_bresp_out, .s_bvalid_out, .s_bready_in, .s_arvalid_in, .s_arready_out, .s_rdata_out,
   .s_rvalid_out, .s_rready_in, .prog_do_in, .base_do_out, .exp_do_out, .marker_out);

// ### verification/program_partner.sv
// Circuit program model that feeds marker cells and program outputs.
`timescale 1ns/10ps
module program_partner
   import relay_pkg::*;
(
   // Clock and wanted program values.
   input  wire logic                   mclk_in,
   input  wire logic [NUM_MARKERS-1:0] pattern_in,
   // Drives toward the block.
   output logic [NUM_MARKERS-1:0]      marker_drv_out,
   output logic [19:0]                 do_drv_out
);
   // System markers are left to the device; the charset cell is in the program.
   always_ff @(posedge mclk_in)
   begin
      marker_drv_out <= pattern_in & ~64'h0000_0000_7B00_0080;
      do_drv_out     <= pattern_in[19:0];
   end
endmodule : program_partner

// ### verification/tb_input_filter_markers.sv
// Self-checking bench for the input filter and marker block.
`timescale 1ns/10ps
module tb_input_filter_markers
   import relay_pkg::*;
;
   localparam logic [31:0] ANY = 32'hXXXX_XXXX;
   logic mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
   logic [11:0] s_awaddr_in = '0, s_araddr_in = '0;
   logic [31:0] s_wdata_in = '0, s_rdata_out, w;
   logic s_awvalid_in = 0, s_wvalid_in = 0, s_bready_in = 0, s_arvalid_in = 0, s_rready_in = 0;
   logic s_awready_out, s_wready_out, s_bvalid_out, s_arready_out, s_rvalid_out;
   logic [1:0] s_bresp_out, s_rresp_out;
   logic [23:0] din_pin_in = '0, prog_di_out;
   logic [3:0] analog_ch_en_out;
   logic [7:0][15:0] analog_in_in = '0, analog_out_out;
   logic [19:0] prog_do;
   logic [63:0] prog_marker, marker_out, pat = '0, blank = '0, cset2 = '0, msg_show_out;
   wire [5:0] lights;
   int fails = 0, checks_done = 0, cyc = 0;

   input_filter_markers #(.MS_CYC(10)) u_dut (.mclk_in, .rst_in, .ce_in, .s_awaddr_in,
      .s_awvalid_in, .s_awready_out, .s_wdata_in, .s_wstrb_in(4'hF), .s_wvalid_in,
      .s_wready_out, .s_bresp_out, .s_bvalid_out, .s_bready_in, .s_araddr_in, .s_arvalid_in,
      .s_arready_out, .s_rdata_out, .s_rresp_out, .s_rvalid_out, .s_rready_in, .din_pin_in,
      .prog_di_out, .analog_ch_en_out, .analog_in_in, .prog_do_in(prog_do), .base_do_out(),
      .exp_do_out(), .prog_marker_in(prog_marker), .marker_out, .blank_sink_in(blank),
      .msg_charset2_in(cset2), .msg_show_out, .analog_out_out,
      .run_light_base_out(lights[5]), .run_light_display_out(lights[4]),
      .setup_light_base_out(lights[3]), .setup_light_display_out(lights[2]),
      .fault_light_base_out(lights[1]), .fault_light_display_out(lights[0]));
   program_partner u_prog (.mclk_in, .pattern_in(pat), .marker_drv_out(prog_marker),
      .do_drv_out(prog_do));

   // Free-running clock and hang guard.
   always #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         $display("[ERR] %0t timeout", $time);
         conclude();
      end
   end

   task automatic conclude();
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   // One bus cycle; ready is raised late at random to stall the answer.
   task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er, input logic [31:0] ed);
      bit [2:0] pend;
      bit [2:0] rdy;
      pend = wr ? 3'h3 : 3'h4;
      @(posedge mclk_in);
      s_awaddr_in <= a;
      s_araddr_in <= a;
      s_wdata_in <= d;
      {s_arvalid_in, s_wvalid_in, s_awvalid_in} <= pend;
      while (pend != 0)
      begin
         @(negedge mclk_in);
         rdy = {s_arready_out, s_wready_out, s_awready_out};
         @(posedge mclk_in);
         pend = pend & ~rdy;
         {s_arvalid_in, s_wvalid_in, s_awvalid_in} <= pend;
      end
      while ((wr ? s_bvalid_out : s_rvalid_out) !== 1'b1)
         @(negedge mclk_in);
      repeat ($urandom_range(2)) @(posedge mclk_in);
      @(posedge mclk_in);
      s_bready_in <= wr;
      s_rready_in <= !wr;
      @(negedge mclk_in);
      chk(wr ? s_bresp_out : s_rresp_out, er);
      if (!wr && ed !== ANY)
         chk(s_rdata_out, ed);
      @(posedge mclk_in);
      s_bready_in <= 1'b0;
      s_rready_in <= 1'b0;
   endtask : axi

   // Expected filtered inputs t cycles after a change; v is 0 std, 1 slow, 2 slave.
   function automatic logic [23:0] model(input logic [23:0] o, input logic [23:0] n,
                                         input int t, input int v);
      int d;
      model = o;
      for (int i = 0; i < 24; i++)
      begin
         d = (v == 2) ? (n[i] ? SLAVE_ON_MS : SLAVE_HOLD_MS)
           : (v == 1 && i < SLOW_FILT_INPUTS) ? (n[i] ? SLOW_ON_MS : SLOW_OFF_MS)
           : (n[i] ? STD_ON_MS : STD_OFF_MS);
         if (t >= d * 10 + 20)
            model[i] = n[i];
      end
   endfunction : model

   task automatic filt(input int v, input logic [23:0] n, input int ta, tm, tz);
      int tl[3];
      int t;
      logic [23:0] o;
      tl = '{ta, tm, tz};
      t = 0;
      o = din_pin_in;
      @(posedge mclk_in);
      din_pin_in <= n;
      foreach (tl[k])
      begin
         repeat (tl[k] - t) @(negedge mclk_in);
         t = tl[k];
         chk(prog_di_out, model(o, n, t, v));
      end
   endtask : filt

   // Main sequence.
   initial
   begin
      logic [11:0] cv[4] = '{12'h010, 12'h020, 12'h030, 12'h050};
      logic [5:0] lv[4] = '{6'h30, 6'h0C, 6'h0C, 6'h33};
      logic [11:0] cs[4] = '{12'h110, 12'h010, 12'h090, 12'h090};
      bit ps[4] = '{0, 1, 1, 0};
      bit es[4] = '{1, 0, 1, 0};
      logic [31:0] rc[3] = '{{18'h0, LIMIT_BYTES}, {LIMIT_REM, 24'h0}, 32'h0};
      int rn[3] = '{1, 1, 400};
      void'($urandom(32'hA5CE));
      repeat (8) @(posedge mclk_in);
      rst_in <= 1'b0;
      analog_in_in <= {$urandom, $urandom, $urandom, $urandom};
      blank <= {$urandom, $urandom};
      cset2 <= {$urandom, $urandom};
      axi(0, CTRL_OFS, 0, RESP_OKAY, CTRL_RESET);
      axi(0, 12'h0F0, 0, RESP_SLVERR, 32'h0);
      axi(1, CTRL_OFS, 32'h10, RESP_OKAY, ANY);
      repeat (40) if (marker_out[STARTUP_BIT] !== 1'b1) @(negedge mclk_in);
      chk(marker_out[STARTUP_BIT], 1'b1);
      repeat (15) @(negedge mclk_in);
      chk(marker_out[STARTUP_BIT], 1'b0);
      filt(0, 24'($urandom), 30, 70, 70);
      axi(1, CTRL_OFS, 32'h11, RESP_OKAY, ANY);
      filt(1, ~din_pin_in, 160, 230, 280);
      axi(1, CTRL_OFS, 32'h14, RESP_OKAY, ANY);
      filt(2, ~din_pin_in, 30, 900, 1030);
      foreach (cv[k])
      begin
         axi(1, CTRL_OFS, cv[k], RESP_OKAY, ANY);
         repeat (25) @(negedge mclk_in);
         chk(lights, lv[k]);
      end
      foreach (cs[k])
      begin
         @(posedge mclk_in);
         pat[CHARSET_BIT] <= ps[k];
         axi(1, CTRL_OFS, cs[k], RESP_OKAY, ANY);
         repeat (25) @(negedge mclk_in);
         chk(msg_show_out, blank & (es[k] ? cset2 : ~cset2));
      end
      @(posedge mclk_in);
      pat <= {$urandom, $urandom};
      repeat (25) @(negedge mclk_in);
      chk(marker_out[63:32], pat[63:32]);
      w = ~pat[63:32];
      axi(1, MARK_HI_OFS, w, RESP_OKAY, ANY);
      repeat (15) if (marker_out[63:32] !== w) @(negedge mclk_in);
      chk(marker_out[63:32], w);
      axi(1, AMARK_OFS + 12'h014, 32'h1234, RESP_OKAY, ANY);
      axi(1, AOUT_SEL_OFS, 32'h203, RESP_OKAY, ANY);
      axi(1, AOUT_SEL_OFS, 32'h0C0, RESP_SLVERR, ANY);
      repeat (25) @(negedge mclk_in);
      axi(0, AMARK_OFS + 12'h014, 0, RESP_OKAY, 32'h1234);
      chk(analog_out_out[2], analog_in_in[3]);
      axi(1, CTRL_OFS, 32'h12, RESP_OKAY, ANY);
      chk(analog_ch_en_out, 4'h3);
      axi(1, CTRL_OFS, 32'h1A, RESP_OKAY, ANY);
      chk(analog_ch_en_out, 4'hF);
      din_pin_in <= '0;
      repeat (2)
      begin
         repeat (80) @(posedge mclk_in);
         din_pin_in <= 24'h00003C;
         repeat (80) @(posedge mclk_in);
         din_pin_in <= '0;
      end
      repeat (80) @(posedge mclk_in);
      axi(0, HSC_OFS, 0, RESP_OKAY, 32'h0202_0202);
      foreach (rc[k])
      begin
         axi(1, RES_CMD_OFS, 32'h2, RESP_OKAY, ANY);
         axi(1, RES_COST_OFS, rc[k], RESP_OKAY, ANY);
         repeat (rn[k]) axi(1, RES_CMD_OFS, 32'h1, RESP_OKAY, ANY);
         axi(1, RES_CMD_OFS, 32'h1, RESP_SLVERR, ANY);
      end
      conclude();
   end
endmodule : tb_input_filter_markers
